// ==== adc_readout_pkg.sv ====
package adc_readout_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int DATA_RATE_SPS = 1000;
  localparam int PERIOD_CYCLES = 1000000000 / (CLK_PERIOD_NS * DATA_RATE_SPS);
  localparam int POR_CYCLES = 65536;
  localparam int SETTLE_PERIODS_X256 = 16123;
  localparam int SETTLE_DEN = 256;
  localparam int SETTLE_EXTRA_CYCLES = 468;
  localparam int WAKE_SAVING_CYCLES = 2;
  localparam int READY_HIGH_CYCLES = 4;
  localparam int TIMEOUT_PERIODS = 64;
  // Word sizes
  localparam int WORD_BITS = 32;
  localparam int CMD_BITS = 8;
  // Command opcodes
  localparam logic [7:0] CMD_WAKE = 8'h02;
  localparam logic [7:0] CMD_STANDBY = 8'h04;
  localparam logic [7:0] CMD_RESET = 8'h06;
  localparam logic [7:0] CMD_READ_CONT = 8'h10;
  localparam logic [7:0] CMD_STOP_CONT = 8'h11;
  localparam logic [7:0] CMD_READ_DATA = 8'h12;
  localparam logic [7:0] CMD_FILTER_FIR = 8'h20;
  localparam logic [7:0] CMD_FILTER_SINC = 8'h21;
  // Codes and input range
  localparam logic [31:0] CODE_POS_FS = 32'h7fffffff;
  localparam logic [31:0] CODE_NEG_FS = 32'h80000000;
  localparam logic signed [32:0] IN_POS_FS = 33'sh03fffffff;
  localparam logic signed [32:0] IN_NEG_FS = 33'sh1c0000000;
  // Types
  typedef enum logic [4:0] {
    ST_POR = 5'b00001,
    ST_DOWN = 5'b00010,
    ST_STANDBY = 5'b00100,
    ST_SETTLE = 5'b01000,
    ST_RUN = 5'b10000
  } state_t;
  typedef struct packed {
    logic sinc;
    logic cont;
  } cfg_t;
  localparam cfg_t CFG_DEFAULT = '{sinc: 1'b0, cont: 1'b1};
endpackage : adc_readout_pkg

// ==== adc_serial_readout_port.sv ====
`timescale 1ns/100ps
// Function
// R1: Power-down pin low disables conversion and restores default configuration.
// R2: Standby keeps serial port and configuration alive and intact.
// R3: After power-up count 65536 clocks before releasing internal reset.
// R4: First FIR data 62.98046875 periods plus 468 clocks; wake two less.
// R5: Default is FIR path at 1000 samples per second.
// R6: Sample data-in on serial rising edge, change data-out on falling.
// R7: Serial clock low for 64 ready periods resets the serial port.
// R8: Host keeps serial clock low when idle, data-in low in continuous.
// R9: Host finishes continuous readout four clocks before next ready.
// R10: By-command reads survive the next ready edge uncorrupted.
// R11: Ready goes low on new result, high on first serial falling edge.
// R12: Unread results give ready a four-clock high pulse per update.
// R13: 32-bit two's complement, LSB repeats sign, clip LSB special.
// R14: Host may stop after 24 bits; device tolerates truncated reads.
// R15: Sinc path codes are half of FIR path codes.
// R16: FIR saturates at full scale codes; sinc path does not clip.
// R17: Continuous readout after power-up and after read-continuous command.
// R18: MSB on data-out at ready fall; low after 32 bits.
// R19: Stop-continuous suppresses ready; results only on read command.
// R20: Read command on eighth rising edge, data at next ready fall.
// R21: Read command yields new data within zero to one period.
// R22: One-shot is standby, wake, wait ready, read, standby again.
// R23: Reset command acts on first clock after eighth serial rising edge.
// R24: Power-down or standby holds ready high with no new results.
module adc_serial_readout_port
  import adc_readout_pkg::*;
#(
  parameter int PERIOD = PERIOD_CYCLES,
  parameter int POR = POR_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic power_down_pin,
  input wire logic sclk,
  input wire logic din,
  input wire logic signed [32:0] filter_data,
  output logic data_ready_n,
  output logic dout,
  output logic converting
);
  localparam int SETTLE = (PERIOD * SETTLE_PERIODS_X256 + SETTLE_DEN - 1) / SETTLE_DEN
                          + SETTLE_EXTRA_CYCLES;

  state_t state;
  cfg_t cfg;
  logic [2:0] sclk_s;
  logic [1:0] din_s;
  logic [1:0] power_down_pin_s;
  logic sclk_rise;
  logic sclk_fall;
  logic power_down_pin_low;
  logic [31:0] por_cnt;
  logic [31:0] settle_cnt;
  logic [31:0] per_cnt;
  logic [6:0] idle_cnt;
  logic [2:0] bit_cnt;
  logic [6:0] cmd_sr;
  logic [7:0] opcode;
  logic cmd_valid;
  logic cmd_wake;
  logic cmd_standby;
  logic cmd_reset;
  logic read_pend;
  logic settle_done;
  logic tick;
  logic load;
  logic timeout;
  logic serial_clear;
  logic clip_pos;
  logic clip_neg;
  logic [31:0] code;
  logic [31:0] out_sr;

  // Pin synchronisers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sclk_s <= 3'h0;
      din_s <= 2'h0;
      power_down_pin_s <= 2'h3;
    end else begin
      sclk_s <= {sclk_s[1:0], sclk};
      din_s <= {din_s[0], din};
      power_down_pin_s <= {power_down_pin_s[0], power_down_pin};
    end
  end

  assign sclk_rise = sclk_s[1] & ~sclk_s[2];
  assign sclk_fall = ~sclk_s[1] & sclk_s[2];
  assign power_down_pin_low = ~power_down_pin_s[1];

  // Command decode
  assign opcode = {cmd_sr, din_s[1]};
  assign cmd_valid = sclk_rise && (bit_cnt == 3'h7); // [R6] [R20]
  assign cmd_wake = cmd_valid && (opcode == CMD_WAKE);
  assign cmd_standby = cmd_valid && (opcode == CMD_STANDBY);
  assign cmd_reset = cmd_valid && (opcode == CMD_RESET);

  // Power state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= ST_POR;
    end else if (state != ST_POR && power_down_pin_low) begin
      state <= ST_DOWN; // [R1]
    end else if (cmd_reset && state != ST_POR) begin
      state <= ST_SETTLE; // [R23]
    end else begin
      unique case (state)
        ST_POR: begin
          if (por_cnt == 32'(POR - 1)) begin
            state <= ST_SETTLE; // [R3]
          end
        end
        ST_DOWN: begin
          state <= ST_SETTLE;
        end
        ST_STANDBY: begin
          if (cmd_wake) begin
            state <= ST_SETTLE; // [R22]
          end
        end
        ST_SETTLE: begin
          if (cmd_standby) begin
            state <= ST_STANDBY;
          end else if (settle_cnt == 32'h0) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (cmd_standby) begin
            state <= ST_STANDBY; // [R2]
          end
        end
      endcase
    end
  end

  // Power-on reset count
  always_ff @(posedge clk_sys) begin
    if (!rst_n || state != ST_POR) begin
      por_cnt <= 32'h0;
    end else begin
      por_cnt <= por_cnt + 32'h1; // [R3]
    end
  end

  // Settling count to first data
  always_ff @(posedge clk_sys) begin
    if (!rst_n || state == ST_POR || state == ST_DOWN || cmd_reset) begin
      settle_cnt <= 32'(SETTLE - 1); // [R4]
    end else if (state == ST_STANDBY) begin
      settle_cnt <= 32'(SETTLE - 1 - WAKE_SAVING_CYCLES); // [R4]
    end else if (state == ST_SETTLE && settle_cnt != 32'h0) begin
      settle_cnt <= settle_cnt - 32'h1;
    end
  end

  assign settle_done = state == ST_SETTLE && settle_cnt == 32'h0
                       && !cmd_standby && !cmd_reset && !power_down_pin_low;

  // Output period divider
  always_ff @(posedge clk_sys) begin
    if (!rst_n || state != ST_RUN || per_cnt == 32'(PERIOD - 1)) begin
      per_cnt <= 32'h0; // [R5]
    end else begin
      per_cnt <= per_cnt + 32'h1;
    end
  end

  assign tick = settle_done || (state == ST_RUN && per_cnt == 32'(PERIOD - 1)
                && !cmd_standby && !cmd_reset && !power_down_pin_low); // [R24]
  assign converting = state == ST_RUN;

  // Configuration
  always_ff @(posedge clk_sys) begin
    if (!rst_n || state == ST_DOWN || cmd_reset) begin
      cfg <= CFG_DEFAULT; // [R1] [R5] [R17] [R23]
    end else if (cmd_valid) begin
      if (opcode == CMD_READ_CONT) begin
        cfg.cont <= 1'b1; // [R17]
      end else if (opcode == CMD_STOP_CONT) begin
        cfg.cont <= 1'b0; // [R19]
      end else if (opcode == CMD_FILTER_SINC) begin
        cfg.sinc <= 1'b1;
      end else if (opcode == CMD_FILTER_FIR) begin
        cfg.sinc <= 1'b0;
      end
    end
  end

  // Idle clock timeout
  assign timeout = tick && !sclk_s[1] && idle_cnt == 7'(TIMEOUT_PERIODS - 1);
  assign serial_clear = timeout || state == ST_POR || state == ST_DOWN;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || sclk_s[1] || serial_clear) begin
      idle_cnt <= 7'h0;
    end else if (tick) begin
      idle_cnt <= idle_cnt + 7'h1; // [R7]
    end
  end

  // Command shift-in
  always_ff @(posedge clk_sys) begin
    if (!rst_n || serial_clear) begin
      bit_cnt <= 3'h0; // [R7]
      cmd_sr <= 7'h0;
    end else if (sclk_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      cmd_sr <= opcode[6:0]; // [R6]
    end
  end

  // Read-by-command request
  always_ff @(posedge clk_sys) begin
    if (!rst_n || serial_clear || state == ST_STANDBY) begin
      read_pend <= 1'b0;
    end else if (cmd_valid && opcode == CMD_READ_DATA) begin
      read_pend <= 1'b1; // [R20] [R21]
    end else if (tick) begin
      read_pend <= 1'b0;
    end
  end

  // Output code
  assign clip_pos = filter_data > IN_POS_FS;
  assign clip_neg = filter_data < IN_NEG_FS;

  always_comb begin
    if (cfg.sinc) begin
      code = filter_data[31:0]; // [R15] [R16]
    end else if (clip_pos) begin
      code = CODE_POS_FS; // [R16] [R13]
    end else if (clip_neg) begin
      code = CODE_NEG_FS; // [R16] [R13]
    end else begin
      code = {filter_data[30:0], filter_data[30]}; // [R13]
    end
  end

  // Result shift-out
  assign load = tick && (cfg.cont || read_pend); // [R10] [R19]

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      out_sr <= 32'h0;
    end else if (load) begin
      out_sr <= code; // [R18]
    end else if (serial_clear) begin
      out_sr <= 32'h0; // [R7]
    end else if (sclk_fall) begin
      out_sr <= {out_sr[30:0], 1'b0}; // [R6] [R14] [R18]
    end
  end

  assign dout = out_sr[WORD_BITS-1];

  // Data ready strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_n || (state != ST_RUN && !settle_done)) begin
      data_ready_n <= 1'b1; // [R24]
    end else if (load) begin
      data_ready_n <= 1'b0; // [R11] [R20]
    end else if (sclk_fall) begin
      data_ready_n <= 1'b1; // [R11]
    end else if (per_cnt == 32'(PERIOD - 1 - READY_HIGH_CYCLES)) begin
      data_ready_n <= 1'b1; // [R12]
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_power_down_pin_idle: assert property (power_down_pin_low && state != ST_POR |=> state == ST_DOWN ##1 cfg == CFG_DEFAULT) // [R1]
    else $error("power-down did not idle and restore defaults");
  a_standby_keep: assert property (state == ST_STANDBY && !cmd_valid && !power_down_pin_low |=> $stable(cfg)) // [R2]
    else $error("configuration changed in standby");
  a_por_release: assert property (state == ST_POR && por_cnt == 32'(POR - 1) |=> state == ST_SETTLE) // [R3]
    else $error("internal reset not released at count end");
  a_wake_settle: assert property ($past(state) == ST_STANDBY && state == ST_SETTLE // [R4]
    |-> settle_cnt == ($past(cmd_reset) ? 32'(SETTLE - 1) : 32'(SETTLE - 1 - WAKE_SAVING_CYCLES)))
    else $error("wake settling count wrong");
  a_timeout_clear: assert property (timeout |=> bit_cnt == 3'h0 // [R7]
    && out_sr == ($past(load) ? $past(code) : 32'h0))
    else $error("timeout did not reset serial port");
  a_ready_ack: assert property (sclk_fall && !load && state == ST_RUN |=> data_ready_n) // [R11]
    else $error("ready not released by serial clock");
  a_ready_pulse: assert property (state == ST_RUN && per_cnt == 32'(PERIOD - 1 - READY_HIGH_CYCLES) // [R12]
    && !power_down_pin_low && !cmd_valid |=> data_ready_n [*4])
    else $error("ready high pulse too short");
  a_fir_clip: assert property (load && !cfg.sinc && clip_pos |=> out_sr == CODE_POS_FS) // [R16]
    else $error("positive clip code wrong");
  a_sign_lsb: assert property (load && !cfg.sinc && !clip_pos && !clip_neg // [R13]
    |=> out_sr[0] == out_sr[WORD_BITS-1])
    else $error("lsb does not repeat sign");
  a_msb_first: assert property (load |=> dout == $past(code[WORD_BITS-1]) && !data_ready_n) // [R18]
    else $error("msb not on data-out at ready fall");
  a_stop_quiet: assert property (!cfg.cont && !read_pend && data_ready_n |=> data_ready_n) // [R19]
    else $error("ready strobed in stop-continuous mode");

  c_cont_read: cover property (load && cfg.cont ##[1:300] sclk_fall);
  c_cmd_read: cover property (load && !cfg.cont);
  c_wake: cover property (state == ST_STANDBY ##1 state == ST_SETTLE);
  c_timeout: cover property (timeout);
endmodule : adc_serial_readout_port

// ==== adc_host_model.sv ====
`timescale 1ns/100ps
module adc_host_model (
  output logic sclk,
  output logic din
);
  initial begin
    sclk = 1'b0;
    din = 1'b0;
  end
  // Shifts n bits, command byte first, then low fill
  task automatic xfer(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      din = (i < 8) ? b[7 - i] : 1'b0;
      #100 sclk = 1'b1;
      #100 sclk = 1'b0;
    end
    din = 1'b0;
  endtask : xfer
endmodule : adc_host_model

// ==== adc_serial_readout_port_tb_top.sv ====
`timescale 1ns/100ps
module adc_serial_readout_port_tb_top;
  import adc_readout_pkg::*;
  localparam int PER = 336;
  localparam int PORC = 32;
  localparam int SETTLE = (PER * SETTLE_PERIODS_X256 + SETTLE_DEN - 1) / SETTLE_DEN + SETTLE_EXTRA_CYCLES;
  typedef struct packed {
    logic [39:0] w;
    logic [5:0] n;
  } note_t;
  logic clk_sys, rst_n, power_down_pin, data_ready_n, dout, converting, sinc;
  logic signed [32:0] filter_data;
  logic signed [29:0] r;
  wire logic sclk, din;
  int miscompares, compares, cnt;
  note_t notes[$];
  logic signed [32:0] vals [4] = '{33'sh07fffffff, 33'sh180000000, IN_POS_FS, IN_NEG_FS};
  adc_host_model i_host (.sclk(sclk), .din(din));
  adc_serial_readout_port #(.PERIOD(PER), .POR(PORC)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .power_down_pin(power_down_pin), .sclk(sclk), .din(din), .filter_data(filter_data),
    .data_ready_n(data_ready_n), .dout(dout), .converting(converting));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  function automatic logic [31:0] code(input logic signed [32:0] v);
    if (sinc) return v[31:0];
    if (v > IN_POS_FS) return CODE_POS_FS;
    if (v < IN_NEG_FS) return CODE_NEG_FS;
    return {v[30:0], v[30]};
  endfunction : code
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic wait_fall(input int lim);
    cnt = 0;
    while (data_ready_n !== 1'b1 && cnt < lim) begin tick; cnt++; end
    while (data_ready_n !== 1'b0 && cnt < lim) begin tick; cnt++; end
    if (cnt >= lim) check("ready fall", 40'h0, 40'h1);
  endtask : wait_fall
  task automatic win(input string what, input int lo, input int hi);
    check(what, 40'(cnt >= lo && cnt <= hi), 40'h1);
  endtask : win
  // Continuous read when cmd is zero, else by command
  task automatic get(input logic signed [32:0] v, input int n, input logic [7:0] cmd);
    if (cmd == 8'h00) wait_fall(PER + 8);
    filter_data = v;
    notes.push_back(note_t'{w: {code(v), 8'h00}, n: 6'(n)});
    if (cmd != 8'h00) i_host.xfer(cmd, 8);
    wait_fall(2 * PER + 8);
    if (cmd != 8'h00) win("read latency", 0, PER + 8);
    i_host.xfer(8'h00, n);
  endtask : get
  task automatic quiet(input string what);
    cnt = 0;
    repeat (2 * PER) begin tick; if (data_ready_n !== 1'b1) cnt++; end
    check(what, 40'(cnt), 40'h0);
  endtask : quiet
  // Compares shifted-out words against notes
  initial begin
    note_t nt;
    logic [39:0] got;
    forever begin
      @(negedge data_ready_n);
      if (notes.size() > 0) begin
        nt = notes[0];
        got = '0;
        for (int i = 0; i < nt.n; i++) begin @(posedge sclk); got[39 - i] = dout; end
        void'(notes.pop_front());
        check("word", got, nt.w & ~(40'hffffffffff >> nt.n));
      end
    end
  end
  initial begin
    #((PORC + 3 * SETTLE + 60 * PER) * 25);
    miscompares++;
    $display("MISMATCH run time expected done seen hang");
    conclude;
  end
  initial begin
    rst_n = 1'b0;
    power_down_pin = 1'b1;
    filter_data = '0;
    sinc = 1'b0;
    miscompares = 0;
    compares = 0;
    void'($urandom(32'ha553));
    repeat (3) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    wait_fall(PORC + SETTLE + 50);
    win("first data", PORC + SETTLE - 4, PORC + SETTLE + 8);
    for (int i = 0; i < 7; i++) begin
      r = 30'($urandom);
      get(i < 4 ? vals[i] : 33'(r), i == 5 ? 24 : (i == 6 ? 40 : 32), 8'h00);
    end
    wait_fall(PER + 8);
    while (data_ready_n === 1'b0 && cnt < 2 * PER) begin tick; cnt++; end
    cnt = 0;
    while (data_ready_n === 1'b1 && cnt < PER) begin tick; cnt++; end
    check("ready pulse", 40'(cnt), 40'(READY_HIGH_CYCLES));
    i_host.xfer(CMD_FILTER_SINC, 8);
    sinc = 1'b1;
    get(33'sh07fff0000, 32, 8'h00);
    r = 30'($urandom);
    get(33'(r), 32, 8'h00);
    wait_fall(PER + 8);
    i_host.xfer(CMD_STOP_CONT, 8);
    quiet("ready blocked");
    r = 30'($urandom);
    get(33'(r), 32, CMD_READ_DATA);
    i_host.xfer(CMD_READ_CONT, 8);
    i_host.xfer(CMD_STANDBY, 8);
    repeat (4) tick;
    check("standby run", 40'(converting), 40'h0);
    quiet("standby ready");
    i_host.xfer(CMD_WAKE, 8);
    wait_fall(SETTLE + 50);
    win("wake data", SETTLE - 8, SETTLE + 4);
    r = 30'($urandom);
    get(33'(r), 32, 8'h00);
    tick;
    power_down_pin = 1'b0;
    repeat (4) tick;
    check("down run", 40'(converting), 40'h0);
    check("down ready", 40'(data_ready_n), 40'h1);
    power_down_pin = 1'b1;
    sinc = 1'b0;
    wait_fall(SETTLE + 50);
    win("down data", SETTLE - 4, SETTLE + 8);
    r = 30'($urandom);
    get(33'(r), 32, 8'h00);
    repeat (PER) tick;
    check("notes left", 40'(notes.size()), 40'h0);
    conclude;
  end
endmodule : adc_serial_readout_port_tb_top
